// ---- core/qp_bus_pkg.sv ----
package qp_bus_pkg;

    // -------------------------------------------------------------------
    // Widths and grouping
    // -------------------------------------------------------------------
    localparam int DATA_W     = 64;
    localparam int GROUPS     = 4;
    localparam int GROUP_W    = 16;
    localparam int SUBPHASES  = 4;
    localparam int FIFO_DEPTH = 16;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int BUS_CLK_PERIOD_NS = 64;
    localparam int PHASE_COUNT       = BUS_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam int CYCLES_PER_WORD   = PHASE_COUNT / SUBPHASES;
    localparam int PHASE_W           = 3;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 3'h0;
    localparam logic [PHASE_W-1:0] PHASE_LAST  = 3'h7;
    // Strobe edges, each one cycle after its word is put on the lines
    localparam logic [PHASE_W-1:0] POS_FALL_A = 3'h1;
    localparam logic [PHASE_W-1:0] NEG_RISE_A = 3'h1;
    localparam logic [PHASE_W-1:0] POS_RISE_A = 3'h3;
    localparam logic [PHASE_W-1:0] NEG_FALL_A = 3'h3;
    localparam logic [PHASE_W-1:0] POS_FALL_B = 3'h5;
    localparam logic [PHASE_W-1:0] NEG_RISE_B = 3'h5;
    localparam logic [PHASE_W-1:0] POS_RISE_B = 3'h7;
    localparam logic [PHASE_W-1:0] NEG_FALL_B = 3'h7;

    // -------------------------------------------------------------------
    // Coding and reset values
    // -------------------------------------------------------------------
    localparam logic [4:0]        INV_THRESHOLD = 5'h08;
    localparam logic [4:0]        BURST_WORDS   = 5'h04;
    localparam logic [DATA_W-1:0] DATA_IDLE     = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [GROUPS-1:0] GROUP_IDLE    = 4'hF;
    localparam logic              LINE_IDLE     = 1'h1;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_SEND = 2'h1,
        TX_TAIL = 2'h3
    } tx_state_t;

    // Logical ones in a group; with normal polarity each one is a low line
    function automatic logic [4:0] ones_count(input logic [GROUP_W-1:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < GROUP_W; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction

    // Line level to logical value for one group
    function automatic logic [GROUP_W-1:0] group_decode(input logic [GROUP_W-1:0] lines,
                                                        input logic inv_n);
        return inv_n ? ~lines : lines;
    endfunction

endpackage

// ---- core/qp_link_if.sv ----
interface qp_link_if;

    // -------------------------------------------------------------------
    // Driver side of each pin
    // -------------------------------------------------------------------
    logic                                  bus_clk;
    logic [qp_bus_pkg::DATA_W-1:0]         data_n_o;
    logic                                  data_n_oe;
    logic [qp_bus_pkg::GROUPS-1:0]         strobe_pos_n_o;
    logic [qp_bus_pkg::GROUPS-1:0]         strobe_neg_n_o;
    logic [qp_bus_pkg::GROUPS-1:0]         invert_flag_n_o;
    logic                                  strobe_oe;
    logic                                  valid_n_o;
    logic                                  valid_n_oe;

    // -------------------------------------------------------------------
    // Wire levels, terminated high when nobody drives
    // -------------------------------------------------------------------
    logic [qp_bus_pkg::DATA_W-1:0]         data_n;
    logic [qp_bus_pkg::GROUPS-1:0]         group_strobe_pos_n;
    logic [qp_bus_pkg::GROUPS-1:0]         group_strobe_neg_n;
    logic [qp_bus_pkg::GROUPS-1:0]         group_invert_flag_n;
    logic                                  transfer_valid_n;

    assign data_n              = data_n_oe  ? data_n_o        : qp_bus_pkg::DATA_IDLE;
    assign group_strobe_pos_n  = strobe_oe  ? strobe_pos_n_o  : qp_bus_pkg::GROUP_IDLE;
    assign group_strobe_neg_n  = strobe_oe  ? strobe_neg_n_o  : qp_bus_pkg::GROUP_IDLE;
    assign group_invert_flag_n = strobe_oe  ? invert_flag_n_o : qp_bus_pkg::GROUP_IDLE;
    assign transfer_valid_n    = valid_n_oe ? valid_n_o       : qp_bus_pkg::LINE_IDLE;

    modport drv (
        output bus_clk,
        output data_n_o,
        output data_n_oe,
        output strobe_pos_n_o,
        output strobe_neg_n_o,
        output invert_flag_n_o,
        output strobe_oe,
        output valid_n_o,
        output valid_n_oe
    );

    modport rcv (
        input bus_clk,
        input data_n,
        input group_strobe_pos_n,
        input group_strobe_neg_n,
        input group_invert_flag_n,
        input transfer_valid_n
    );

endinterface

// ---- core/stream_fifo.sv ----
module stream_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    // Fill side
    input  wire logic [WIDTH-1:0]           in_data,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    // Drain side
    output logic [WIDTH-1:0]                out_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;
    logic             ready_r;
    logic             push;
    logic             pop;

    // -------------------------------------------------------------------
    // Pointers and fill level
    // -------------------------------------------------------------------
    always_comb begin
        push       = in_valid & ready_r;
        pop        = out_ready & (count_r != '0);
        wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'h1) : wr_ptr_r;
        rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'h1) : rd_ptr_r;
        count_nxt  = count_r;
        if (push && !pop) begin
            count_nxt = CW'(count_r + 1'h1);
        end else if (pop && !push) begin
            count_nxt = CW'(count_r - 1'h1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            ready_r  <= 1'h0;
        end else if (ce) begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            ready_r  <= (count_nxt != FULL_COUNT);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ce && push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    assign in_ready  = ready_r;
    assign out_data  = mem[rd_ptr_r];
    assign out_valid = (count_r != '0);
    assign count     = count_r;

endmodule // stream_fifo

// ---- core/qp_data_driver.sv ----
// Operation
// - all 64 data lines carried between agents
// - driver marks valid data with qualifier low
// - four words driven per bus clock period
// - receiver latches on both strobes' falling edges
// - four 16-bit groups, own strobes and flag
// - active flag: group taken active high
// - flag travels with data, set when inverted
// - invert group when over half lines low
module qp_data_driver (
    // Clock, reset, enable
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    // User words
    input  wire logic [qp_bus_pkg::DATA_W-1:0] in_data,
    input  wire logic                          in_valid,
    output logic                               in_ready,
    // Options and status
    input  wire logic                          inv_enable,
    output logic                               busy,
    // Bus
    qp_link_if.drv                             link
);
    localparam int DW = qp_bus_pkg::DATA_W;
    localparam int GN = qp_bus_pkg::GROUPS;
    localparam int GW = qp_bus_pkg::GROUP_W;
    localparam int PW = qp_bus_pkg::PHASE_W;

    // -------------------------------------------------------------------
    // Word buffer
    // -------------------------------------------------------------------
    logic [DW-1:0] head_data;
    logic          head_valid;
    logic          pop;
    logic [4:0]    fill;

    stream_fifo #(
        .WIDTH (DW),
        .DEPTH (qp_bus_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_data   (in_data),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (head_data),
        .out_valid (head_valid),
        .out_ready (pop),
        .count     (fill)
    );

    // -------------------------------------------------------------------
    // Inversion coding of the word at the head
    // -------------------------------------------------------------------
    logic [DW-1:0] enc_data;
    logic [GN-1:0] enc_flag_n;

    always_comb begin
        logic [GW-1:0] grp;
        grp        = '0;
        enc_data   = qp_bus_pkg::DATA_IDLE;
        enc_flag_n = qp_bus_pkg::GROUP_IDLE;
        for (int g = 0; g < GN; g++) begin
            grp = head_data[g*GW +: GW];
            // More ones than the threshold means most lines would sit low
            if (inv_enable && (qp_bus_pkg::ones_count(grp) > qp_bus_pkg::INV_THRESHOLD)) begin
                enc_data[g*GW +: GW] = grp;
                enc_flag_n[g]        = 1'h0;
            end else begin
                enc_data[g*GW +: GW] = ~grp;
                enc_flag_n[g]        = 1'h1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Burst sequencer and bus clock
    // -------------------------------------------------------------------
    qp_bus_pkg::tx_state_t state_r;
    qp_bus_pkg::tx_state_t state_nxt;
    logic [PW-1:0] phase_r;
    logic [PW-1:0] phase_nxt;
    logic          bus_clk_r;
    logic          bus_clk_nxt;
    logic [DW-1:0] data_r;
    logic [DW-1:0] data_nxt;
    logic [GN-1:0] flag_n_r;
    logic [GN-1:0] flag_n_nxt;
    logic [GN-1:0] pos_n_r;
    logic [GN-1:0] pos_n_nxt;
    logic [GN-1:0] neg_n_r;
    logic [GN-1:0] neg_n_nxt;
    logic          valid_n_r;
    logic          valid_n_nxt;
    logic          oe_r;
    logic          oe_nxt;
    logic          busy_r;
    logic          busy_nxt;
    logic          load;

    always_comb begin
        state_nxt   = state_r;
        phase_nxt   = PW'(phase_r + 1'h1);
        bus_clk_nxt = ~phase_nxt[PW-1];
        data_nxt    = data_r;
        flag_n_nxt  = flag_n_r;
        pos_n_nxt   = pos_n_r;
        neg_n_nxt   = neg_n_r;
        valid_n_nxt = valid_n_r;
        oe_nxt      = oe_r;
        load        = 1'h0;
        case (state_r)
            qp_bus_pkg::TX_IDLE: begin
                pos_n_nxt = qp_bus_pkg::GROUP_IDLE;
                neg_n_nxt = qp_bus_pkg::GROUP_IDLE;
                // A burst only starts aligned to the bus clock with a full line queued
                if ((phase_r == qp_bus_pkg::PHASE_LAST) && (fill >= qp_bus_pkg::BURST_WORDS)) begin
                    state_nxt   = qp_bus_pkg::TX_SEND;
                    oe_nxt      = 1'h1;
                    valid_n_nxt = 1'h0;
                    load        = 1'h1;
                end
            end
            qp_bus_pkg::TX_SEND: begin
                // One new word every two cycles, four per bus clock
                if ((phase_nxt[0] == 1'h0) && (phase_nxt != qp_bus_pkg::PHASE_RESET)) begin
                    load = 1'h1;
                end
                case (phase_nxt)
                    qp_bus_pkg::POS_FALL_A: begin
                        pos_n_nxt = '0;
                        neg_n_nxt = qp_bus_pkg::GROUP_IDLE;
                    end
                    qp_bus_pkg::POS_RISE_A: begin
                        pos_n_nxt = qp_bus_pkg::GROUP_IDLE;
                        neg_n_nxt = '0;
                    end
                    qp_bus_pkg::POS_FALL_B: begin
                        pos_n_nxt = '0;
                        neg_n_nxt = qp_bus_pkg::GROUP_IDLE;
                    end
                    qp_bus_pkg::POS_RISE_B: begin
                        pos_n_nxt = qp_bus_pkg::GROUP_IDLE;
                        neg_n_nxt = '0;
                    end
                    default: begin
                        pos_n_nxt = pos_n_r;
                        neg_n_nxt = neg_n_r;
                    end
                endcase
                if (phase_r == qp_bus_pkg::PHASE_LAST) begin
                    state_nxt   = qp_bus_pkg::TX_TAIL;
                    valid_n_nxt = 1'h1;
                    pos_n_nxt   = qp_bus_pkg::GROUP_IDLE;
                    neg_n_nxt   = qp_bus_pkg::GROUP_IDLE;
                    data_nxt    = qp_bus_pkg::DATA_IDLE;
                    flag_n_nxt  = qp_bus_pkg::GROUP_IDLE;
                end
            end
            qp_bus_pkg::TX_TAIL: begin
                // One cycle driving the idle level before letting go of the lines
                state_nxt = qp_bus_pkg::TX_IDLE;
                oe_nxt    = 1'h0;
            end
            default: begin
                state_nxt   = qp_bus_pkg::TX_IDLE;
                oe_nxt      = 1'h0;
                valid_n_nxt = 1'h1;
            end
        endcase
        if (load) begin
            data_nxt   = enc_data;
            flag_n_nxt = enc_flag_n;
        end
        busy_nxt = (state_nxt != qp_bus_pkg::TX_IDLE);
    end

    assign pop = load & head_valid;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r   <= qp_bus_pkg::TX_IDLE;
            phase_r   <= qp_bus_pkg::PHASE_RESET;
            bus_clk_r <= 1'h0;
            data_r    <= qp_bus_pkg::DATA_IDLE;
            flag_n_r  <= qp_bus_pkg::GROUP_IDLE;
            pos_n_r   <= qp_bus_pkg::GROUP_IDLE;
            neg_n_r   <= qp_bus_pkg::GROUP_IDLE;
            valid_n_r <= qp_bus_pkg::LINE_IDLE;
            oe_r      <= 1'h0;
            busy_r    <= 1'h0;
        end else if (ce) begin
            state_r   <= state_nxt;
            phase_r   <= phase_nxt;
            bus_clk_r <= bus_clk_nxt;
            data_r    <= data_nxt;
            flag_n_r  <= flag_n_nxt;
            pos_n_r   <= pos_n_nxt;
            neg_n_r   <= neg_n_nxt;
            valid_n_r <= valid_n_nxt;
            oe_r      <= oe_nxt;
            busy_r    <= busy_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Pin drive
    // -------------------------------------------------------------------
    assign link.bus_clk         = bus_clk_r;
    assign link.data_n_o        = data_r;
    assign link.data_n_oe       = oe_r;
    assign link.strobe_pos_n_o  = pos_n_r;
    assign link.strobe_neg_n_o  = neg_n_r;
    assign link.invert_flag_n_o = flag_n_r;
    assign link.strobe_oe       = oe_r;
    assign link.valid_n_o       = valid_n_r;
    assign link.valid_n_oe      = oe_r;
    assign busy                 = busy_r;

endmodule // qp_data_driver

// ---- core/qp_data_receiver.sv ----
module qp_data_receiver (
    // Clock, reset, enable
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    // Bus
    qp_link_if.rcv                             link,
    // User words
    output logic [qp_bus_pkg::DATA_W-1:0]      out_data,
    output logic                               out_valid
);
    localparam int DW = qp_bus_pkg::DATA_W;
    localparam int GN = qp_bus_pkg::GROUPS;
    localparam int GW = qp_bus_pkg::GROUP_W;
    localparam int SW = DW + 3*GN + 1;

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    // Data, flags and strobes share stages so an edge sees its own word
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic [SW-1:0] pins;
    logic [GN-1:0] pos_prev_r;
    logic [GN-1:0] neg_prev_r;

    assign pins = {link.transfer_valid_n, link.group_strobe_pos_n, link.group_strobe_neg_n,
                   link.group_invert_flag_n, link.data_n};

    logic [DW-1:0] s_data;
    logic [GN-1:0] s_flag_n;
    logic [GN-1:0] s_neg_n;
    logic [GN-1:0] s_pos_n;
    logic          s_valid_n;

    assign s_data    = sync2_r[DW-1:0];
    assign s_flag_n  = sync2_r[DW +: GN];
    assign s_neg_n   = sync2_r[DW+GN +: GN];
    assign s_pos_n   = sync2_r[DW+2*GN +: GN];
    assign s_valid_n = sync2_r[SW-1];

    // -------------------------------------------------------------------
    // Group capture and word assembly
    // -------------------------------------------------------------------
    logic [DW-1:0] grp_r;
    logic [DW-1:0] grp_nxt;
    logic [GN-1:0] have_r;
    logic [GN-1:0] have_nxt;
    logic [DW-1:0] out_data_r;
    logic [DW-1:0] out_data_nxt;
    logic          out_valid_r;
    logic          out_valid_nxt;
    logic [GN-1:0] edge_fall;

    always_comb begin
        grp_nxt       = grp_r;
        have_nxt      = have_r;
        out_data_nxt  = out_data_r;
        out_valid_nxt = 1'h0;
        edge_fall     = (pos_prev_r & ~s_pos_n) | (neg_prev_r & ~s_neg_n);
        for (int g = 0; g < GN; g++) begin
            if (edge_fall[g] && !s_valid_n) begin
                grp_nxt[g*GW +: GW] = qp_bus_pkg::group_decode(s_data[g*GW +: GW], s_flag_n[g]);
                have_nxt[g]         = 1'h1;
            end
        end
        if (&have_nxt) begin
            out_data_nxt  = grp_nxt;
            out_valid_nxt = 1'h1;
            have_nxt      = '0;
        end
        // A qualifier drop mid word throws away partial groups
        if (s_valid_n) begin
            have_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_r     <= {SW{1'h1}};
            sync2_r     <= {SW{1'h1}};
            pos_prev_r  <= qp_bus_pkg::GROUP_IDLE;
            neg_prev_r  <= qp_bus_pkg::GROUP_IDLE;
            grp_r       <= '0;
            have_r      <= '0;
            out_data_r  <= '0;
            out_valid_r <= 1'h0;
        end else if (ce) begin
            sync1_r     <= pins;
            sync2_r     <= sync1_r;
            pos_prev_r  <= s_pos_n;
            neg_prev_r  <= s_neg_n;
            grp_r       <= grp_nxt;
            have_r      <= have_nxt;
            out_data_r  <= out_data_nxt;
            out_valid_r <= out_valid_nxt;
        end
    end

    assign out_data  = out_data_r;
    assign out_valid = out_valid_r;

endmodule // qp_data_receiver

// ---- tb/qp_link_sva.sv ----
module qp_link_sva (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Link wires
    input wire logic        bus_clk,
    input wire logic [63:0] data_n,
    input wire logic [3:0]  group_strobe_pos_n,
    input wire logic [3:0]  group_strobe_neg_n,
    input wire logic [3:0]  group_invert_flag_n,
    input wire logic        transfer_valid_n,
    // Drive enables
    input wire logic        data_n_oe,
    input wire logic        strobe_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------
    // Burst steps
    // ------------------------------
    sequence s_start;
        $fell(transfer_valid_n);
    endsequence
    sequence s_strobes;
        $fell(group_strobe_pos_n[0]) ##2 $fell(group_strobe_neg_n[0])
        ##2 $fell(group_strobe_pos_n[0]) ##2 $fell(group_strobe_neg_n[0]);
    endsequence
    sequence s_words;
        $stable(data_n) ##2 $stable(data_n) ##2 $stable(data_n) ##2 $stable(data_n);
    endsequence

    chk_valid_eight: assert property (
        s_start |=> !transfer_valid_n [*7] ##1 transfer_valid_n)
        else $error("valid qualifier not low for eight cycles");
    chk_start_phase: assert property (
        s_start |-> $rose(bus_clk))
        else $error("burst not aligned to bus clock");
    // The divider leaves reset mid phase, so the first high phase is short
    chk_bus_clk_div: assert property (
        $rose(bus_clk) && $past(rst_n, 2) |-> bus_clk [*4] ##1 !bus_clk [*4] ##1 bus_clk)
        else $error("bus clock not divided by eight");
    chk_word_hold: assert property (
        s_start |=> s_words)
        else $error("word not held for two cycles");
    chk_strobe_walk: assert property (
        s_start |=> s_strobes)
        else $error("strobe falls out of order");
    chk_group_lock: assert property (
        group_strobe_pos_n inside {4'h0, 4'hF} && group_strobe_neg_n inside {4'h0, 4'hF})
        else $error("group strobes differ");
    chk_flag_idle: assert property (
        transfer_valid_n |-> group_invert_flag_n == 4'hF)
        else $error("inversion flag outside a transfer");
    chk_tail_release: assert property (
        $rose(transfer_valid_n) |-> data_n == qp_bus_pkg::DATA_IDLE ##1 !data_n_oe && !strobe_oe)
        else $error("tail not idle or bus not released");
    for (genvar g = 0; g < 4; g++) begin : grp
        chk_flag_thresh: assert property (
            !transfer_valid_n && !group_invert_flag_n[g] |-> $countones(data_n[16*g +: 16]) > 8)
            else $error("group inverted at or below half");
    end
endmodule // qp_link_sva

// ---- tb/quad_pumped_data_bus_inversion_tb.sv ----
module quad_pumped_data_bus_inversion_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [63:0] in_data = 64'h0;
    logic        in_valid = 1'b0;
    logic        in_ready;
    logic        inv_enable = 1'b1;
    logic        busy;
    logic [63:0] out_data;
    logic        out_valid;
    logic [63:0] wire_q[$];
    logic [63:0] rx_q[$];
    logic [3:0]  prev_pos = 4'hF;
    logic [3:0]  prev_neg = 4'hF;
    int          bad_count = 0;
    int          checked = 0;

    always #4 sys_clk = ~sys_clk;

    qp_link_if qp_link_if_inst ();
    qp_data_driver qp_data_driver_inst (.sys_clk, .rst_n, .ce, .in_data, .in_valid,
        .in_ready, .inv_enable, .busy, .link(qp_link_if_inst.drv));
    qp_data_receiver qp_data_receiver_inst (.sys_clk, .rst_n, .ce,
        .link(qp_link_if_inst.rcv), .out_data, .out_valid);
    qp_link_sva qp_link_sva_inst (.sys_clk, .rst_n, .bus_clk(qp_link_if_inst.bus_clk),
        .data_n(qp_link_if_inst.data_n), .group_strobe_pos_n(qp_link_if_inst.group_strobe_pos_n),
        .group_strobe_neg_n(qp_link_if_inst.group_strobe_neg_n),
        .group_invert_flag_n(qp_link_if_inst.group_invert_flag_n),
        .transfer_valid_n(qp_link_if_inst.transfer_valid_n),
        .data_n_oe(qp_link_if_inst.data_n_oe), .strobe_oe(qp_link_if_inst.strobe_oe));

    // ------------------------------
    // Checking and closing
    // ------------------------------
    task automatic compare_word(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic compare_flags(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: flags %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic compare_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic time_out();
        bad_count++;
        $display("Error at %0t: wait ran out", $time);
        give_verdict();
    endtask

    // Inverted only when enabled and more than half the lines would be low
    function automatic logic [3:0] exp_flags(input logic [63:0] w);
        logic [3:0] f;
        for (int g = 0; g < 4; g++) begin
            f[g] = !(inv_enable && $countones(w[16*g +: 16]) > 8);
        end
        return f;
    endfunction

    // ------------------------------
    // Monitors
    // ------------------------------
    always @(negedge sys_clk) begin
        logic [3:0]  pos;
        logic [3:0]  neg;
        logic [3:0]  fl;
        logic [63:0] d;
        logic [63:0] w;
        pos = qp_link_if_inst.group_strobe_pos_n;
        neg = qp_link_if_inst.group_strobe_neg_n;
        fl = qp_link_if_inst.group_invert_flag_n;
        d = qp_link_if_inst.data_n;
        if (rst_n && !qp_link_if_inst.transfer_valid_n
            && ((prev_pos & ~pos) | (prev_neg & ~neg)) != 4'h0) begin
            w = (wire_q.size() > 0) ? wire_q.pop_front() : 'x;
            compare_flags(fl, exp_flags(w));
            for (int g = 0; g < 4; g++) begin
                d[16*g +: 16] = fl[g] ? ~d[16*g +: 16] : d[16*g +: 16];
            end
            compare_word(d, w);
        end
        prev_pos = pos;
        prev_neg = neg;
        if (out_valid === 1'b1) begin
            compare_word(out_data, (rx_q.size() > 0) ? rx_q.pop_front() : 'x);
        end
    end

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic push_word(input logic [63:0] w);
        int n;
        n = 0;
        in_data = w;
        in_valid = 1'b1;
        while (in_ready !== 1'b1 && n < 300) begin
            @(posedge sys_clk); #1;
            n++;
        end
        if (n == 300) begin
            time_out();
        end
        wire_q.push_back(w);
        rx_q.push_back(w);
        @(posedge sys_clk); #1;
    endtask
    task automatic drain();
        int   n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while ((wire_q.size() + rx_q.size() > 0 || busy !== 1'b0) && n < 3000) begin
            @(posedge sys_clk); #1;
            seen = seen | (busy === 1'b1);
            n++;
        end
        if (n == 3000) begin
            time_out();
        end
        compare_bit(seen, 1'b1);
    endtask
    // Group counts 0, 8, 9, 15 and 16 ones sit on both sides of the threshold
    task automatic coding_burst(input logic inv);
        logic [63:0] words[4] = '{64'h00FF_01FF_FFFF_0000, 64'h8000_FFFE_7FFF_0001,
                                  64'h1234_5678_9ABC_DEF0, 64'hFFFF_FFFF_FFFF_FFFF};
        inv_enable = inv;
        foreach (words[i]) begin
            push_word(words[i]);
        end
        in_valid = 1'b0;
        drain();
    endtask
    task automatic fill_fifo();
        logic        full;
        logic [63:0] w;
        int          taken;
        full = 1'b0;
        taken = 0;
        in_valid = 1'b1;
        for (int i = 1; i < 80 && !full; i++) begin
            w = 64'(i) * 64'h0F1E_2D3C_4B5A_6978;
            in_data = w;
            if (in_ready === 1'b1) begin
                wire_q.push_back(w);
                rx_q.push_back(w);
                taken++;
            end else begin
                full = 1'b1;
            end
            @(posedge sys_clk); #1;
        end
        compare_bit(full, 1'b1);
        repeat ((4 - taken % 4) % 4) push_word(64'h0000_0000_0000_0000);
        in_valid = 1'b0;
        drain();
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        @(posedge sys_clk); #1;
        coding_burst(1'b1);
        coding_burst(1'b0);
        fill_fifo();
        give_verdict();
    end
endmodule // quad_pumped_data_bus_inversion_tb
